//--- core/see_engine.sv
// serial eeprom command engine: link protocol, page buffer, write cycle, array
`timescale 1ns/10ps
`default_nettype none
`include "see_map.svh"

// Operation
// R1 - writes carry high then low address bytes
// R2 - byte write: id, select, dir zero, data
// R3 - write cycle starts only at stop
// R4 - busy device ignores bus requests
// R5 - page write loads up to 32 bytes
// R6 - ack each write data byte unless protected
// R7 - pointer advances after each data byte
// R8 - over 32 bytes wrap, newer overwrite older
// R9 - short page programs only received bytes
// R10 - no address ack while busy, ack after
// R11 - master polls with start plus address
// R12 - protect: ack addresses, nack data, no write
// R13 - unprotected: whole array writable
// R14 - pointer holds last access plus one
// R15 - read address: ack, send byte at pointer
// R16 - master ends single read with nack, stop
// R17 - random read: dummy write, restart, read
// R18 - after nack and stop release data line
// R19 - master ack sends next byte
// R20 - read pointer wraps over whole array
// R21 - array of 8192 bytes, 13-bit pointer
// R22 - respond only on matching id and straps
// R23 - master nack stops data, await stop
// R24 - page wrap touches low five bits only
// R25 - write cycle length is a parameter
module see_engine
#(
    parameter logic [3:0]  TYPE_ID      = 4'h5,  // arbitrary value
    parameter int unsigned WRITE_CYCLES = `SEE_TWR_US * `SEE_CLK_MHZ
)
(
    input  wire logic       clock_i,
    input  wire logic       srst_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe_n_o,
    input  wire logic       wp_i,
    input  wire logic [2:0] chip_select_straps_i,
    output logic            write_busy_o
);

    // ----------------------------------------------------------------
    // storage and cross-domain state
    // ----------------------------------------------------------------
    logic [7:0]                  mem [`SEE_MEM_BYTES];  // [R21]
    logic [7:0]                  page_buf [`SEE_PAGE_BYTES];
    logic [`SEE_PAGE_BYTES-1:0]  page_mask;
    logic                        wr_pend;
    logic [`SEE_ADDR_W-1:0]      ptr;

    // ----------------------------------------------------------------
    // system clock: pin synchronisers and start/stop detection
    // ----------------------------------------------------------------
    logic [1:0]                  scl_sy;
    logic [1:0]                  sda_sy;
    logic                        scl_d;
    logic                        sda_d;
    logic [1:0]                  pend_sy;
    logic                        start_mark;
    logic                        started;
    logic [1:0]                  armed;
    see_pkg::see_wc_e            wc_state;
    logic [`SEE_PAGE_W-1:0]      wc_idx;
    logic [`SEE_WCNT_W-1:0]      wc_cnt;

    wire bus_start = scl_sy[1] & sda_d & ~sda_sy[1];
    wire bus_stop  = scl_sy[1] & ~sda_d & sda_sy[1];
    wire scl_fall  = scl_d & ~scl_sy[1];
    wire wc_go     = bus_stop & pend_sy[1] & (wc_state == see_pkg::SEE_WC_IDLE); // [R3]
    wire copy_last = (wc_idx == `SEE_PAGE_W'(`SEE_PAGE_BYTES - 1));
    wire mem_we    = (wc_state == see_pkg::SEE_WC_COPY) & page_mask[wc_idx];      // [R9]
    wire [`SEE_ADDR_W-1:0] mem_wa = {ptr[`SEE_ADDR_W-1:`SEE_PAGE_W], wc_idx};    // [R24]

    // the pin copies only feed the second stage; edges use the second and third
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            scl_sy  <= 2'h3;
            sda_sy  <= 2'h3;
            scl_d   <= 1'b1;
            sda_d   <= 1'b1;
            pend_sy <= 2'h0;
        end
        else
        begin
            scl_sy  <= {scl_sy[0], scl_i};
            sda_sy  <= {sda_sy[0], sda_i};
            scl_d   <= scl_sy[1];
            sda_d   <= sda_sy[1];
            pend_sy <= {pend_sy[0], wr_pend};
        end
    end

    // start marker stays up across exactly one falling scl edge, so the
    // link sees it on its second stage at the second fall and no later
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            start_mark <= 1'b0;
            started    <= 1'b0;
            armed      <= 2'h0;
        end
        else
        begin
            start_mark <= bus_start | (start_mark & ~scl_fall);
            started    <= started | bus_start;
            armed      <= armed | {scl_fall & armed[0], scl_fall & ~start_mark & started};
        end
    end

    // ----------------------------------------------------------------
    // system clock: internal write cycle
    // ----------------------------------------------------------------
    // page contents and pointer are frozen while busy because the link
    // refuses every frame then; that is what makes this crossing safe
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            wc_state <= see_pkg::SEE_WC_IDLE;
            wc_idx   <= '0;
            wc_cnt   <= '0;
        end
        else
        begin
            unique case (wc_state)
                see_pkg::SEE_WC_IDLE:
                begin
                    wc_idx <= '0;
                    if (wc_go)
                        wc_state <= see_pkg::SEE_WC_COPY;  // [R3]
                end
                see_pkg::SEE_WC_COPY:
                begin
                    wc_idx <= wc_idx + `SEE_PAGE_W'(1);
                    if (copy_last)
                    begin
                        wc_state <= see_pkg::SEE_WC_WAIT;
                        wc_cnt   <= `SEE_WCNT_W'(WRITE_CYCLES - 1);  // [R25]
                    end
                end
                see_pkg::SEE_WC_WAIT:
                begin
                    wc_cnt <= wc_cnt - `SEE_WCNT_W'(1);
                    if (wc_cnt == '0)
                        wc_state <= see_pkg::SEE_WC_IDLE;
                end
            endcase
        end
    end

    // array programming, one page slot per clock
    always_ff @(posedge clock_i)
    begin
        if (mem_we)
            mem[mem_wa] <= page_buf[wc_idx];  // [R13]
    end

    assign write_busy_o = (wc_state != see_pkg::SEE_WC_IDLE);

    // ----------------------------------------------------------------
    // link clock: synchronisers (falling scl edge)
    // ----------------------------------------------------------------
    logic [`SEE_SYNC_W-1:0]      lk_meta;
    logic [`SEE_SYNC_W-1:0]      lk_sync;
    logic                        sda_p;

    wire                         lk_rst   = lk_sync[6];
    wire                         lk_start = lk_sync[5];
    wire                         lk_busy  = lk_sync[4];
    wire                         lk_wp    = lk_sync[3];
    wire [2:0]                   lk_sel   = lk_sync[2:0];

    always_ff @(negedge scl_i)
    begin
        lk_meta <= {srst_i, start_mark, write_busy_o, wp_i, chip_select_straps_i};
        lk_sync <= lk_meta;
    end

    // data is sampled where the master guarantees it stable
    always_ff @(posedge scl_i)
    begin
        sda_p <= sda_i;
    end

    // ----------------------------------------------------------------
    // link clock: frame decoding
    // ----------------------------------------------------------------
    see_pkg::see_link_e          state;
    see_pkg::see_link_e          next_state;
    logic [`SEE_BCNT_W-1:0]      bcnt;
    logic [`SEE_BCNT_W-1:0]      next_bcnt;
    logic [7:0]                  shreg;
    logic [7:0]                  txreg;
    logic [7:0]                  next_txreg;
    logic [7:0]                  ahi;
    logic                        drive;
    logic                        next_drive;
    logic [`SEE_ADDR_W-1:0]      next_ptr;

    wire [7:0] rx_byte  = {shreg[6:0], sda_p};
    wire [7:0] rd_byte  = mem[ptr];                                    // [R15]
    wire       id_hit   = (rx_byte[`SEE_ID_HI:`SEE_ID_LO] == TYPE_ID)
                        & (rx_byte[`SEE_SEL_HI:`SEE_SEL_LO] == lk_sel); // [R22]
    wire       rx_st    = (state == see_pkg::SEE_LK_DEV) | (state == see_pkg::SEE_LK_AHI)
                        | (state == see_pkg::SEE_LK_ALO) | (state == see_pkg::SEE_LK_WDATA);
    wire       byte_end = rx_st & ~lk_start & (bcnt == `SEE_BIT_LAST);
    wire       ack_end  = rx_st & ~lk_start & (bcnt == `SEE_BIT_ACK);
    wire       buf_we   = byte_end & (state == see_pkg::SEE_LK_WDATA) & ~lk_wp; // [R6]
    wire       dev_ack  = id_hit & ~lk_busy;                                   // [R10]
    wire [15:0] addr_word   = {ahi, rx_byte};                                  // [R1]
    wire [`SEE_ADDR_W-1:0] ptr_next_rd = ptr + `SEE_ADDR_W'(1);
    wire [`SEE_ADDR_W-1:0] ptr_next_wr =
        {ptr[`SEE_ADDR_W-1:`SEE_PAGE_W], ptr[`SEE_PAGE_W-1:0] + `SEE_PAGE_W'(1)}; // [R24]

    // acknowledge decision for the byte that completes at this edge
    logic ack_ok;
    always_comb
    begin
        unique case (state)
            see_pkg::SEE_LK_DEV:   ack_ok = dev_ack;
            see_pkg::SEE_LK_WDATA: ack_ok = ~lk_wp;  // [R12]
            default:               ack_ok = 1'b1;    // [R12]
        endcase
    end

    // frame sequencer; a restart always wins over the current phase
    always_comb
    begin
        next_state = state;
        next_bcnt  = bcnt;
        next_txreg = txreg;
        next_drive = drive;
        next_ptr   = ptr;
        if (lk_start)
        begin
            next_state = see_pkg::SEE_LK_DEV;
            next_bcnt  = `SEE_BIT_SYNCED;
            next_drive = 1'b0;
        end
        else if (byte_end)
        begin
            next_bcnt  = `SEE_BIT_ACK;
            next_drive = ack_ok;  // [R6]
            if (state == see_pkg::SEE_LK_ALO)
                next_ptr = addr_word[`SEE_ADDR_W-1:0];  // [R1]
            else if (buf_we)
                next_ptr = ptr_next_wr;  // [R7]
        end
        else if (ack_end)
        begin
            next_bcnt  = '0;
            next_drive = 1'b0;
            unique case (state)
                see_pkg::SEE_LK_DEV:
                    if (!drive)
                        next_state = see_pkg::SEE_LK_IDLE;  // [R4]
                    else if (shreg[`SEE_RW_BIT])
                    begin
                        next_state = see_pkg::SEE_LK_RDATA;  // [R15]
                        next_txreg = rd_byte;
                        next_drive = ~rd_byte[7];
                        next_bcnt  = `SEE_BIT_FIRST;
                        next_ptr   = ptr_next_rd;  // [R14]
                    end
                    else
                        next_state = see_pkg::SEE_LK_AHI;  // [R2]
                see_pkg::SEE_LK_AHI:   next_state = see_pkg::SEE_LK_ALO;  // [R1]
                see_pkg::SEE_LK_ALO:   next_state = see_pkg::SEE_LK_WDATA;
                see_pkg::SEE_LK_WDATA:
                    if (!drive)
                        next_state = see_pkg::SEE_LK_IDLE;  // [R12]
                default:               next_state = state;
            endcase
        end
        else if (rx_st)
            next_bcnt = bcnt + `SEE_BCNT_W'(1);
        else if (state == see_pkg::SEE_LK_RDATA)
        begin
            if (bcnt == `SEE_BIT_ACK)
            begin
                next_drive = 1'b0;
                next_bcnt  = `SEE_BIT_MACK;
            end
            else if (bcnt == `SEE_BIT_MACK)
            begin
                if (!sda_p)
                begin
                    next_txreg = rd_byte;  // [R19]
                    next_drive = ~rd_byte[7];
                    next_bcnt  = `SEE_BIT_FIRST;
                    next_ptr   = ptr_next_rd;  // [R20]
                end
                else
                    next_state = see_pkg::SEE_LK_IDLE;  // [R23] [R18]
            end
            else
            begin
                next_txreg = {txreg[6:0], 1'b0};
                next_drive = ~txreg[6];
                next_bcnt  = bcnt + `SEE_BCNT_W'(1);
            end
        end
        else
            next_drive = 1'b0;
    end

    // ----------------------------------------------------------------
    // link clock: registers
    // ----------------------------------------------------------------
    always_ff @(negedge scl_i)
    begin
        if (lk_rst)
        begin
            state <= see_pkg::SEE_LK_IDLE;
            bcnt  <= '0;
            drive <= 1'b0;
        end
        else
        begin
            state <= next_state;
            bcnt  <= next_bcnt;
            drive <= next_drive;
        end
    end

    // the restart is seen two bits late; keep the bit the shifter already holds
    always_ff @(negedge scl_i)
    begin
        txreg <= next_txreg;
        ptr   <= next_ptr;
        shreg <= lk_start ? {6'h00, shreg[0], sda_p} : rx_byte;
        if (byte_end & (state == see_pkg::SEE_LK_AHI))
            ahi <= rx_byte;  // [R1]
    end

    // page buffer: a restart discards what the last frame loaded; an
    // overrun lands on the same slot again, so the newest byte wins
    always_ff @(negedge scl_i)
    begin
        if (lk_rst | lk_start)
        begin
            page_mask <= '0;
            wr_pend   <= 1'b0;
        end
        else if (buf_we)
        begin
            page_buf[ptr[`SEE_PAGE_W-1:0]]  <= rx_byte;  // [R8] [R5]
            page_mask[ptr[`SEE_PAGE_W-1:0]] <= 1'b1;     // [R9]
            wr_pend                         <= 1'b1;     // [R3]
        end
    end

    // ----------------------------------------------------------------
    // pin
    // ----------------------------------------------------------------
    // the line is only pulled low; released until the link state is defined
    assign sda_o      = 1'b0;
    assign sda_oe_n_o = ~(armed[1] & drive);

endmodule
`default_nettype wire

//--- core/see_map.svh
// constants of the serial eeprom command engine
`ifndef SEE_MAP_SVH
`define SEE_MAP_SVH

// ----------------------------------------------------------------
// array geometry
// ----------------------------------------------------------------
`define SEE_MEM_BYTES   8192
`define SEE_ADDR_W      13
`define SEE_PAGE_BYTES  32
`define SEE_PAGE_W      5
`define SEE_BASE_W      8

// ----------------------------------------------------------------
// bit counting inside one byte frame
// ----------------------------------------------------------------
`define SEE_BCNT_W      4
`define SEE_BIT_FIRST   4'h1
`define SEE_BIT_SYNCED  4'h2  // bits already shifted in when a start reaches the link
`define SEE_BIT_LAST    4'h7
`define SEE_BIT_ACK     4'h8
`define SEE_BIT_MACK    4'h9

// ----------------------------------------------------------------
// slave address fields and link-side synchroniser vector
// ----------------------------------------------------------------
`define SEE_ID_HI       7
`define SEE_ID_LO       4
`define SEE_SEL_HI      3
`define SEE_SEL_LO      1
`define SEE_RW_BIT      0
`define SEE_SYNC_W      7

// ----------------------------------------------------------------
// write cycle timing
// ----------------------------------------------------------------
`define SEE_TWR_US      3000
`define SEE_CLK_MHZ     250
`define SEE_WCNT_W      20

`endif

//--- core/see_pkg.sv
// types shared by the serial eeprom command engine
package see_pkg;

    // link-side frame phases
    typedef enum logic [2:0] {
        SEE_LK_IDLE,
        SEE_LK_DEV,
        SEE_LK_AHI,
        SEE_LK_ALO,
        SEE_LK_WDATA,
        SEE_LK_RDATA
    } see_link_e;

    // internal write cycle phases
    typedef enum logic [1:0] {
        SEE_WC_IDLE,
        SEE_WC_COPY,
        SEE_WC_WAIT
    } see_wc_e;

endpackage

//--- verification/see_checker.sv
// port-level assertions for the eeprom command engine
`timescale 1ns/10ps
`default_nettype none
module see_checker
#(
    parameter int unsigned WRITE_CYCLES = 50
)
(
    input  wire logic       clock_i,
    input  wire logic       srst_i,
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic       sda_o,
    input  wire logic       sda_oe_n_o,
    input  wire logic       wp_i,
    input  wire logic [2:0] chip_select_straps_i,
    input  wire logic       write_busy_o
);
    localparam int BUSY_LEN = 32 + WRITE_CYCLES;
    logic       scl_q;
    logic       sda_q;
    logic       wp_stop;
    logic [3:0] since_stop;
    int         busy_cnt;
    wire logic  stop_seen = scl_q && scl_i && !sda_q && sda_i;

    // line samples; the stop distance saturates so a stale stop never counts
    always_ff @(posedge clock_i)
    begin
        scl_q <= scl_i;
        sda_q <= sda_i;
        if (srst_i)
            since_stop <= 4'hf;
        else if (stop_seen)
            since_stop <= 4'h0;
        else if (since_stop != 4'hf)
            since_stop <= since_stop + 4'h1;
        if (stop_seen)
            wp_stop <= wp_i;
        busy_cnt <= write_busy_o ? busy_cnt + 1 : 0;
    end

    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (srst_i);

    chk_open_drain_low: assert property (sda_o == 1'b0)
        else $error("data output is not held low");
    chk_oe_on_scl_low: assert property ($changed(sda_oe_n_o) |-> !scl_i)
        else $error("data enable moved while clock high");
    chk_busy_no_ack: assert property (write_busy_o |-> sda_oe_n_o)
        else $error("device pulled data while busy");
    chk_busy_after_stop: assert property ($rose(write_busy_o) |-> since_stop <= 4'h8)
        else $error("write cycle began without a stop");
    chk_protect_no_cycle: assert property ($rose(write_busy_o) |-> !wp_stop)
        else $error("write cycle began while protected");
    chk_busy_steady: assert property ($rose(write_busy_o) |=> write_busy_o [*8])
        else $error("write cycle dropped early");
    chk_busy_length: assert property ($fell(write_busy_o) |->
        busy_cnt >= BUSY_LEN - 1 && busy_cnt <= BUSY_LEN + 1)
        else $error("write cycle length wrong");
    chk_idle_after_stop: assert property (stop_seen |-> sda_oe_n_o [*6])
        else $error("data driven after stop");

    cover property ($rose(write_busy_o));
    cover property ($fell(sda_oe_n_o));
    cover property (stop_seen && wp_i);
endmodule

bind see_engine see_checker #(.WRITE_CYCLES(WRITE_CYCLES)) i_see_checker
(
    .clock_i, .srst_i, .scl_i, .sda_i, .sda_o, .sda_oe_n_o, .wp_i,
    .chip_select_straps_i, .write_busy_o
);
`default_nettype wire

//--- verification/see_master.sv
// behavioural two-wire bus master; clock stands high between frames
`timescale 1ns/10ps
`default_nettype none
module see_master
(
    output logic      scl_o,
    output logic      sda_low_o,
    input  wire logic sda_i
);
    initial
    begin
        scl_o = 1'b1;
        sda_low_o = 1'b0;
    end

    // start or repeated start; long clock-high time lets the slave see it
    task automatic start();
        #7.5 sda_low_o = 1'b0;
        #7.5 scl_o = 1'b1;
        #30 sda_low_o = 1'b1;
        #30 scl_o = 1'b0;
    endtask

    task automatic stop();
        #7.5 sda_low_o = 1'b1;
        #7.5 scl_o = 1'b1;
        #30 sda_low_o = 1'b0;
        #30;
    endtask

    // send one byte msb first, sample the ninth bit
    task automatic put(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--)
        begin
            #7.5 sda_low_o = ~b[i];
            #7.5 scl_o = 1'b1;
            #15 scl_o = 1'b0;
        end
        #7.5 sda_low_o = 1'b0;
        #7.5 ack = ~sda_i;
        scl_o = 1'b1;
        #15 scl_o = 1'b0;
    endtask

    // receive one byte; a nack leaves the line to the pull-up
    task automatic get(input logic ack, output logic [7:0] b);
        for (int i = 7; i >= 0; i--)
        begin
            #7.5 sda_low_o = 1'b0;
            #7.5 b[i] = sda_i;
            scl_o = 1'b1;
            #15 scl_o = 1'b0;
        end
        #7.5 sda_low_o = ack;
        #7.5 scl_o = 1'b1;
        #15 scl_o = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- verification/serial_eeprom_command_engine_tb_top.sv
// self-checking bench for the eeprom command engine with a byte model
`timescale 1ns/10ps
`default_nettype none
module serial_eeprom_command_engine_tb_top;
    localparam logic [3:0] TID = 4'h5;  // arbitrary type code
    logic        clock_i = 1'b0;
    logic        srst_i = 1'b1;
    logic        wp_i = 1'b0;
    logic [2:0]  sel = 3'h0;
    logic        scl;
    logic        m_low;
    logic        sda_o;
    logic        oe_n;
    logic        busy;
    wire logic   sda = !(m_low || (!oe_n && !sda_o));
    logic [7:0]  mem [int];
    int          ptr;
    int          n_fail = 0;
    int          checked = 0;
    logic [31:0] seed = 32'h4033;

    see_engine #(.TYPE_ID(TID), .WRITE_CYCLES(100)) i_see_engine
    (
        .clock_i(clock_i), .srst_i(srst_i), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe_n_o(oe_n), .wp_i(wp_i),
        .chip_select_straps_i(sel), .write_busy_o(busy)
    );
    see_master i_see_master (.scl_o(scl), .sda_low_o(m_low), .sda_i(sda));

    always #2 clock_i = ~clock_i;

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [7:0] dev(input logic rw);
        return {TID, sel, rw};
    endfunction

    task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d, mismatches %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // polling: nacked while the cycle runs, acked once it is over
    task automatic poll();
        logic ack;
        int   k;
        k = 0;
        ack = 1'b0;
        cmp({7'h0, busy}, 8'h1);
        while (!ack && k < 40)
        begin
            i_see_master.start();
            i_see_master.put(dev(1'b0), ack);
            i_see_master.stop();
            if (k == 0)
                cmp({7'h0, ack}, 8'h0);
            k++;
        end
        cmp({6'h0, ack, busy}, 8'h2);
    endtask

    // write frame; zero data bytes leaves the bus open for a read
    task automatic wr(input int a, input int n);
        logic       ack;
        logic [7:0] d;
        int         pg;
        pg = a & 8160;
        i_see_master.start();
        i_see_master.put(dev(1'b0), ack);
        cmp({7'h0, ack}, 8'h1);
        i_see_master.put(8'(a >> 8), ack);
        cmp({7'h0, ack}, 8'h1);
        i_see_master.put(8'(a), ack);
        cmp({7'h0, ack}, 8'h1);
        ptr = a;
        for (int i = 0; i < n; i++)
        begin
            d = 8'(rnd());
            i_see_master.put(d, ack);
            cmp({7'h0, ack}, {7'h0, !wp_i});
            if (wp_i)
                break;
            mem[pg | ((a + i) & 31)] = d;
            ptr = pg | ((a + i + 1) & 31);
        end
        if (n > 0)
        begin
            i_see_master.stop();
            if (!wp_i)
                poll();
            else
                cmp({7'h0, busy}, 8'h0);
        end
    endtask

    // read from the pointer, acking all bytes but the last
    task automatic rd(input int n);
        logic       ack;
        logic [7:0] b;
        i_see_master.start();
        i_see_master.put(dev(1'b1), ack);
        cmp({7'h0, ack}, 8'h1);
        for (int i = 0; i < n; i++)
        begin
            i_see_master.get(i < n - 1, b);
            cmp(b, mem[ptr]);
            ptr = (ptr + 1) % 8192;
        end
        i_see_master.stop();
        cmp({7'h0, oe_n}, 8'h1);
    endtask

    // main sequence; offset keeps bus edges apart from clock edges
    initial
    begin
        int   pg;
        logic ack;
        repeat (16) @(negedge clock_i);
        srst_i = 1'b0;
        sel = 3'(rnd());
        #1.3;
        i_see_master.start();
        i_see_master.put({TID ^ 4'h1, sel, 1'b0}, ack);
        cmp({7'h0, ack}, 8'h0);
        i_see_master.stop();
        i_see_master.start();
        i_see_master.put({TID, sel ^ 3'h1, 1'b0}, ack);
        cmp({7'h0, ack}, 8'h0);
        i_see_master.stop();
        pg = (rnd() % 250) * 32;
        wr(pg + 30, 34);
        wr(pg + 32, 3);
        wr(pg, 0);
        rd(32);
        rd(3);
        @(negedge clock_i) wp_i = 1'b1;
        #1.3;
        wr(pg + 32, 2);
        @(negedge clock_i) wp_i = 1'b0;
        #1.3;
        wr(pg + 32, 0);
        rd(3);
        wr(8191, 1);
        wr(0, 1);
        wr(8191, 0);
        rd(2);
        summarize();
    end

    // hang guard, far beyond the few tens of microseconds the run needs
    initial
    begin
        #200000;
        n_fail++;
        summarize();
    end
endmodule
`default_nettype wire
